/* hdl/avalon_slave.sv */
// avalon-mm slave front end: one wait state, then a one-cycle request pulse gated by the ack register
`timescale 1ns/1ps
module avalon_slave
   import port_ctl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [3:0]  address,
   input  wire logic [31:0] writedata,
   output logic             waitrequest,
   output bus_req_t         req
);
   logic ack_reg;

   // the first cycle always waits so that read data settle from registers
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read || write) && !ack_reg;
      end
   end

   assign waitrequest = !ack_reg;

   always_comb begin
      req.rd    = read && ack_reg;
      req.wr    = write && ack_reg;
      req.addr  = address;
      req.wdata = writedata;
   end
endmodule

/* hdl/interval_timer.sv */
// down-counter that reports one pulse when a loaded interval has elapsed
`timescale 1ns/1ps
module interval_timer
   import port_ctl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        load,
   input  wire logic [31:0] count,
   input  wire logic        abort,
   output logic             done
);
   logic [31:0] cnt_reg;
   logic        run_reg;

   always_ff @(posedge clk) begin
      if (rst || abort) begin
         cnt_reg <= 32'h0;
         run_reg <= 1'b0;
      end else if (load) begin
         cnt_reg <= count - 32'h1;
         run_reg <= 1'b1;
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 32'h1;
         if (cnt_reg == 32'h1) begin
            run_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst || abort || load) begin
         done <= 1'b0;
      end else begin
         done <= run_reg && (cnt_reg == 32'h1);
      end
   end
endmodule

/* hdl/port_ctl_pkg.sv */
// constants, types and the rule summary for the root hub port status/control block
// What this block does
// (R1) set-reset write starts downstream reset; reset bit reads 1 while reset runs
// (R2) reset end raises reset-done change and clears the reset bit together
// (R3) software writes 1 at the reset bit to start reset; 0 is ignored
// (R4) set-reset with nothing attached starts nothing and raises the attach indication
// (R5) overcurrent bit reads 0 unless overcurrent is reported per port
// (R6) per-port mode: overcurrent bit shows the live overcurrent condition
// (R7) writing 1 to bit 3 resumes only a suspended port; 0 does nothing
// (R8) set-suspend sets suspend bit; held through resume; cleared with suspend-done change
// (R9) set-suspend with nothing attached leaves suspend clear, raises attach indication
// (R10) suspend bit also clears at reset completion and controller wake state; code clears it when a reset starts from suspend
// (R11) downstream resume during suspend is passed on to the controller
// (R12) enable bit may clear on overcurrent, disconnect, power off or bus error
// (R13) a hardware clear of enable also raises the enable change flag
// (R14) set-enable and clear-enable writes set and clear the enable bit
// (R15) enable never sets while no device is attached
// (R16) enable sets at reset completion and at suspend-sequence completion
// (R17) set-enable with nothing attached raises attach change flag instead
// (R18) bit 0 shows attachment; writes never change it
// (R19) power off clears attach, enable, suspend and reset bits
// (R20) downstream reset is held about 10 ms before completion is reported
package port_ctl_pkg;
   localparam logic [3:0] ADDR_STATUS  = 4'h0;  // word index 0: status/command
   localparam logic [3:0] ADDR_CHANGE  = 4'h1;  // word index 1: change flags, write 1 clears
   localparam logic [3:0] ADDR_CONFIG  = 4'h2;  // word index 2: configuration
   localparam int BIT_ATTACH   = 0;
   localparam int BIT_ENABLE   = 1;
   localparam int BIT_SUSPEND  = 2;
   localparam int BIT_OVERCUR  = 3;
   localparam int BIT_RESET    = 4;
   localparam int BIT_CLR_EN   = 0;   // clear-enable command position
   localparam int BIT_POWER    = 8;   // power status / set-power command
   localparam int BIT_CLR_PWR  = 9;   // clear-power command position
   localparam int CHG_ATTACH   = 0;
   localparam int CHG_ENABLE   = 1;
   localparam int CHG_SUSPEND  = 2;
   localparam int CHG_OVERCUR  = 3;
   localparam int CHG_RESET    = 4;
   localparam int CFG_PERPORT  = 0;
   localparam int CLK_MHZ      = 250;
   localparam int RESET_MS     = 10;
   localparam int RESET_CYCLES = RESET_MS * 1000 * CLK_MHZ;
   localparam int RESUME_MS    = 20;
   localparam int RESUME_CYCLES = RESUME_MS * 1000 * CLK_MHZ;
   localparam logic [4:0]  CHG_RESET_VAL = 5'h00;
   localparam logic        CFG_RESET_VAL = 1'b0;

   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_RESET   = 2'b01,
      ST_SUSPEND = 2'b10,
      ST_RESUME  = 2'b11
   } port_state_t;

   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [3:0]  addr;
      logic [31:0] wdata;
   } bus_req_t;

   typedef struct packed {
      logic attached;
      logic overcurrent;
      logic bus_error;
      logic remote_wake;
      logic ctl_wake;
   } port_in_t;
endpackage

/* hdl/root_port_ctl.sv */
// root hub port status and control with avalon-mm register access
`timescale 1ns/1ps
module root_port_ctl
   import port_ctl_pkg::*;
#(
   parameter int RESET_LEN  = RESET_CYCLES,
   parameter int RESUME_LEN = RESUME_CYCLES
) (
   input  wire logic        CLK,
   input  wire logic        SYS_RST,
   input  wire logic [3:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        DEV_ATTACHED,
   input  wire logic        DEV_OVERCURRENT,
   input  wire logic        DEV_BUS_ERROR,
   input  wire logic        DEV_REMOTE_WAKE,
   input  wire logic        CTL_WAKE_STATE,
   output logic             PORT_RESET_DRIVE,
   output logic             PORT_SUSPEND_DRIVE,
   output logic             PORT_RESUME_DRIVE,
   output logic             WAKE_TO_CTL
);
   bus_req_t    req;
   logic        slave_wait;
   port_in_t    pin;
   port_state_t state_reg;
   logic        port_reset_active;
   logic        port_suspended_flag;
   logic        port_enabled_flag;
   logic        port_power_reg;
   logic        perport_oc_reg;
   logic [4:0]  change_reg;
   logic        attach_change_indication;
   logic        tmr_load;
   logic [31:0] tmr_count;
   logic        tmr_done;
   logic        wr_status;
   logic        wr_change;
   logic        wr_config;
   logic        set_reset;
   logic        set_suspend;
   logic        set_resume;
   logic        set_enable;
   logic        clr_enable;
   logic        set_power;
   logic        clr_power;
   logic        reset_done;
   logic        suspend_done;
   logic        hw_disable;
   logic        start_reset;
   logic        start_resume;
   logic        device_attached_flag;
   logic        port_overcurrent_flag;
   logic [31:0] status_word;
   logic [31:0] rdata_next;

   function automatic logic wbit(input bus_req_t r, input int pos);
      return r.wdata[pos];
   endfunction

   always_comb begin
      pin.attached    = DEV_ATTACHED;
      pin.overcurrent = DEV_OVERCURRENT;
      pin.bus_error   = DEV_BUS_ERROR;
      pin.remote_wake = DEV_REMOTE_WAKE;
      pin.ctl_wake    = CTL_WAKE_STATE;
   end

   avalon_slave u_slave (
      .clk         (CLK),
      .rst         (SYS_RST),
      .read        (AVS_READ),
      .write       (AVS_WRITE),
      .address     (AVS_ADDRESS),
      .writedata   (AVS_WRITEDATA),
      .waitrequest (slave_wait),
      .req         (req)
   );

   // the attach bit only counts while the port is powered
   assign device_attached_flag  = pin.attached && port_power_reg; // R18 R19
   assign port_overcurrent_flag = perport_oc_reg && pin.overcurrent; // R5 R6

   assign wr_status   = req.wr && (req.addr == ADDR_STATUS);
   assign wr_change   = req.wr && (req.addr == ADDR_CHANGE);
   assign wr_config   = req.wr && (req.addr == ADDR_CONFIG);
   assign set_reset   = wr_status && wbit(req, BIT_RESET); // R3
   assign set_suspend = wr_status && wbit(req, BIT_SUSPEND);
   assign set_resume  = wr_status && wbit(req, BIT_OVERCUR); // R7
   assign set_enable  = wr_status && wbit(req, BIT_ENABLE);
   assign clr_enable  = wr_status && wbit(req, BIT_CLR_EN);
   assign set_power   = wr_status && wbit(req, BIT_POWER);
   assign clr_power   = wr_status && wbit(req, BIT_CLR_PWR);
   assign reset_done   = (state_reg == ST_RESET) && tmr_done;
   assign suspend_done = (state_reg == ST_RESUME) && tmr_done;
   // overcurrent, disconnect and bus error pull the port out of service
   assign hw_disable  = port_enabled_flag &&
                        (pin.overcurrent || !device_attached_flag || pin.bus_error); // R12

   // reset may not start on a detached port; the attach indication reports it
   assign attach_change_indication =
      (set_reset || set_suspend || set_enable) && !device_attached_flag; // R4 R9 R17

   // a suspended port may be reset too; the controller wake state still wins
   assign start_reset  = set_reset && device_attached_flag &&
                         (state_reg == ST_IDLE || (state_reg == ST_SUSPEND && !pin.ctl_wake));
   assign start_resume = (state_reg == ST_SUSPEND) && !pin.ctl_wake && !set_reset &&
                         (set_resume || pin.remote_wake);
   assign tmr_load  = start_reset || start_resume;
   assign tmr_count = start_reset ? 32'(RESET_LEN) : 32'(RESUME_LEN);

   interval_timer u_timer (
      .clk   (CLK),
      .rst   (SYS_RST),
      .load  (tmr_load),
      .count (tmr_count),
      .abort (!device_attached_flag),
      .done  (tmr_done)
   );

   // port sequence: reset, suspend, resume
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         state_reg <= ST_IDLE;
      end else if (!device_attached_flag) begin
         state_reg <= ST_IDLE; // R19
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (set_reset) begin
                  state_reg <= ST_RESET; // R1
               end else if (set_suspend) begin
                  state_reg <= ST_SUSPEND; // R8
               end
            end
            ST_RESET: begin
               if (tmr_done) begin
                  state_reg <= ST_IDLE; // R20
               end
            end
            ST_SUSPEND: begin
               if (pin.ctl_wake) begin
                  state_reg <= ST_IDLE; // R10
               end else if (set_reset) begin
                  state_reg <= ST_RESET; // R1 R10
               end else if (set_resume || pin.remote_wake) begin
                  state_reg <= ST_RESUME; // R7 R11
               end
            end
            ST_RESUME: begin
               if (tmr_done) begin
                  state_reg <= ST_IDLE;
               end else if (pin.ctl_wake) begin
                  state_reg <= ST_IDLE; // R10
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   assign port_reset_active   = (state_reg == ST_RESET); // R1 R2
   assign port_suspended_flag = (state_reg == ST_SUSPEND) || (state_reg == ST_RESUME); // R8

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         port_power_reg <= 1'b0;
      end else if (pin.overcurrent) begin
         port_power_reg <= 1'b0;
      end else if (clr_power) begin
         port_power_reg <= 1'b0;
      end else if (set_power) begin
         port_power_reg <= 1'b1;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         port_enabled_flag <= 1'b0;
      end else if (!device_attached_flag || hw_disable) begin
         port_enabled_flag <= 1'b0; // R12 R15 R19
      end else if (reset_done || suspend_done) begin
         port_enabled_flag <= 1'b1; // R16
      end else if (clr_enable) begin
         port_enabled_flag <= 1'b0; // R14
      end else if (set_enable) begin
         port_enabled_flag <= 1'b1; // R14 R17
      end
   end

   // hardware sets win over a same-cycle write-1 clear
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         change_reg <= CHG_RESET_VAL;
      end else begin
         change_reg <= (change_reg & ~(wr_change ? req.wdata[4:0] : 5'h00)) | {
            reset_done, // R2
            pin.overcurrent && perport_oc_reg,
            suspend_done, // R8
            hw_disable, // R13
            attach_change_indication // R4 R9 R17
         };
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         perport_oc_reg <= CFG_RESET_VAL;
      end else if (wr_config) begin
         perport_oc_reg <= req.wdata[CFG_PERPORT];
      end
   end

   always_comb begin
      status_word = 32'h0;
      status_word[BIT_ATTACH]  = device_attached_flag;
      status_word[BIT_ENABLE]  = port_enabled_flag;
      status_word[BIT_SUSPEND] = port_suspended_flag;
      status_word[BIT_OVERCUR] = port_overcurrent_flag;
      status_word[BIT_RESET]   = port_reset_active;
      status_word[BIT_POWER]   = port_power_reg;
   end

   always_comb begin
      case (AVS_ADDRESS)
         ADDR_STATUS: rdata_next = status_word;
         ADDR_CHANGE: rdata_next = {27'h0, change_reg};
         ADDR_CONFIG: rdata_next = {31'h0, perport_oc_reg};
         default:     rdata_next = 32'h0;
      endcase
   end

   // read data are latched in the wait cycle and stand at the release edge
   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         AVS_READDATA <= 32'h0;
      end else if (AVS_READ && slave_wait) begin
         AVS_READDATA <= rdata_next;
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && slave_wait && AVS_WAITREQUEST);
      end
   end

   always_ff @(posedge CLK) begin
      if (SYS_RST) begin
         PORT_RESET_DRIVE   <= 1'b0;
         PORT_SUSPEND_DRIVE <= 1'b0;
         PORT_RESUME_DRIVE  <= 1'b0;
         WAKE_TO_CTL        <= 1'b0;
      end else begin
         PORT_RESET_DRIVE   <= (state_reg == ST_RESET); // R1
         PORT_SUSPEND_DRIVE <= (state_reg == ST_SUSPEND);
         PORT_RESUME_DRIVE  <= (state_reg == ST_RESUME);
         WAKE_TO_CTL        <= (state_reg == ST_SUSPEND) && pin.remote_wake; // R11
      end
   end

   property p_reset_blocked;
      @(posedge CLK) disable iff (SYS_RST)
      (set_reset && !device_attached_flag) |=> !port_reset_active && change_reg[CHG_ATTACH];
   endproperty
   a_reset_blocked: assert property (p_reset_blocked) else $error("reset began on empty port"); // R4

   property p_reset_end;
      @(posedge CLK) disable iff (SYS_RST)
      (reset_done && device_attached_flag && !hw_disable)
         |=> !port_reset_active && change_reg[CHG_RESET] && port_enabled_flag;
   endproperty
   a_reset_end: assert property (p_reset_end) else $error("reset completion wrong"); // R2

   property p_enable_needs_attach;
      @(posedge CLK) disable iff (SYS_RST)
      !device_attached_flag |=> !port_enabled_flag;
   endproperty
   a_enable_needs_attach: assert property (p_enable_needs_attach) else $error("enabled detached"); // R15

   property p_hw_disable;
      @(posedge CLK) disable iff (SYS_RST)
      hw_disable |=> !port_enabled_flag && change_reg[CHG_ENABLE];
   endproperty
   a_hw_disable: assert property (p_hw_disable) else $error("fault disable missed"); // R13

   property p_oc_hidden;
      @(posedge CLK) disable iff (SYS_RST)
      !perport_oc_reg |-> !status_word[BIT_OVERCUR];
   endproperty
   a_oc_hidden: assert property (p_oc_hidden) else $error("overcurrent bit shown"); // R5

   property p_suspend_set;
      @(posedge CLK) disable iff (SYS_RST)
      (state_reg == ST_IDLE && set_suspend && !set_reset && device_attached_flag)
         |=> port_suspended_flag;
   endproperty
   a_suspend_set: assert property (p_suspend_set) else $error("suspend not set"); // R8

   property p_suspend_blocked;
      @(posedge CLK) disable iff (SYS_RST)
      (set_suspend && !device_attached_flag) |=> !port_suspended_flag;
   endproperty
   a_suspend_blocked: assert property (p_suspend_blocked) else $error("suspended empty"); // R9

   property p_wake;
      @(posedge CLK) disable iff (SYS_RST)
      (state_reg == ST_SUSPEND && pin.remote_wake) |=> WAKE_TO_CTL;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not passed on"); // R11

   property p_reset_start;
      @(posedge CLK) disable iff (SYS_RST)
      (state_reg == ST_IDLE && start_reset) |=> port_reset_active ##1 PORT_RESET_DRIVE;
   endproperty
   a_reset_start: assert property (p_reset_start) else $error("reset did not start"); // R1

   property p_ctl_wake;
      @(posedge CLK) disable iff (SYS_RST)
      (port_suspended_flag && pin.ctl_wake) |=> !port_suspended_flag;
   endproperty
   a_ctl_wake: assert property (p_ctl_wake) else $error("suspend kept in wake"); // R10

   property p_reset_unsuspend;
      @(posedge CLK) disable iff (SYS_RST)
      reset_done |=> !port_suspended_flag;
   endproperty
   a_reset_unsuspend: assert property (p_reset_unsuspend) else $error("suspend kept"); // R10

   property p_resume_end;
      @(posedge CLK) disable iff (SYS_RST)
      (suspend_done && device_attached_flag && !hw_disable)
         |=> !port_suspended_flag && change_reg[CHG_SUSPEND] && port_enabled_flag;
   endproperty
   a_resume_end: assert property (p_resume_end) else $error("resume completion wrong"); // R16

   property p_resume_idle;
      @(posedge CLK) disable iff (SYS_RST)
      (set_resume && state_reg == ST_IDLE) |=> state_reg != ST_RESUME;
   endproperty
   a_resume_idle: assert property (p_resume_idle) else $error("resumed idle port"); // R7

   property p_oc_read;
      @(posedge CLK) disable iff (SYS_RST)
      (AVS_READ && slave_wait && AVS_ADDRESS == ADDR_STATUS && !perport_oc_reg)
         |=> !AVS_READDATA[BIT_OVERCUR];
   endproperty
   a_oc_read: assert property (p_oc_read) else $error("overcurrent bit read"); // R5

   property p_attach_read;
      @(posedge CLK) disable iff (SYS_RST)
      (AVS_READ && slave_wait && AVS_ADDRESS == ADDR_STATUS)
         |=> AVS_READDATA[BIT_ATTACH] == $past(device_attached_flag);
   endproperty
   a_attach_read: assert property (p_attach_read) else $error("attach bit read wrong"); // R18
endmodule

/* sim/test_root_port_ctl.sv */
// self-checking bench for the root hub port status and control block
`timescale 1ns/1ps
module test_root_port_ctl;
   import port_ctl_pkg::*;
   localparam int RST_LEN = 20;
   localparam int RSM_LEN = 30;
   localparam logic [31:0] C_CLREN = 32'h001;
   localparam logic [31:0] C_SETEN = 32'h002;
   localparam logic [31:0] C_SUSP  = 32'h004;
   localparam logic [31:0] C_RES   = 32'h008;
   localparam logic [31:0] C_RST   = 32'h010;
   localparam logic [31:0] C_PWR   = 32'h100;
   localparam logic [31:0] C_NOPWR = 32'h200;
   logic        CLK = 1'b0;
   logic        SYS_RST = 1'b1;
   logic [3:0]  AVS_ADDRESS = 4'h0;
   logic        AVS_READ = 1'b0;
   logic        AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic        AVS_WAITREQUEST;
   logic        DEV_ATTACHED, DEV_OVERCURRENT, DEV_BUS_ERROR, DEV_REMOTE_WAKE;
   logic        CTL_WAKE_STATE = 1'b0;
   logic        PORT_RESET_DRIVE, PORT_SUSPEND_DRIVE, PORT_RESUME_DRIVE, WAKE_TO_CTL;
   logic        plug = 1'b1, oc = 1'b0, err = 1'b0, wake = 1'b0;
   logic [3:0]  wdly = 4'h0;
   logic [3:0]  ra;
   logic [31:0] q, rdat;
   logic [31:0] cmds [3];
   int          failures = 0, tests_run = 0, rcnt = 0, i;

   always #2 CLK = ~CLK;
   always @(posedge CLK) if (PORT_RESET_DRIVE === 1'b1) rcnt <= rcnt + 1;

   root_port_ctl #(.RESET_LEN(RST_LEN), .RESUME_LEN(RSM_LEN)) i_root_port_ctl (
      .CLK, .SYS_RST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
      .AVS_READDATA, .AVS_WAITREQUEST, .DEV_ATTACHED, .DEV_OVERCURRENT,
      .DEV_BUS_ERROR, .DEV_REMOTE_WAKE, .CTL_WAKE_STATE, .PORT_RESET_DRIVE,
      .PORT_SUSPEND_DRIVE, .PORT_RESUME_DRIVE, .WAKE_TO_CTL);

   usb_dev_model i_usb_dev_model (
      .clk(CLK), .plug, .oc, .err, .wake, .wake_dly(wdly),
      .suspend_in(PORT_SUSPEND_DRIVE), .attached(DEV_ATTACHED),
      .overcurrent(DEV_OVERCURRENT), .bus_error(DEV_BUS_ERROR),
      .remote_wake(DEV_REMOTE_WAKE));

   function automatic logic [31:0] st(input logic a, e, s, o, r, p);
      st = {23'h0, p, 3'h0, r, o, s, e, a};
   endfunction

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // holds the request until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge CLK);
      AVS_READ <= !w;
      AVS_WRITE <= w;
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      n = 0;
      do begin
         @(posedge CLK);
         n++;
      end while (AVS_WAITREQUEST !== 1'b0 && n < 100);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
      chk({31'h0, AVS_WAITREQUEST}, 32'h0);
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff);
      bus(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge CLK);
   endtask

   // polls the status word; the bound only guards against a stuck bit
   task automatic waitclr(input int b);
      for (int k = 0; k < 40; k++) begin
         bus(1'b0, 4'h0, 32'h0);
         if (q[b] === 1'b0) break;
      end
      chk({31'h0, q[b]}, 32'h0);
   endtask

   initial begin
      q = $urandom(13830);
      cmds = '{C_RST, C_SUSP, C_SETEN};
      repeat (8) @(posedge CLK);
      SYS_RST <= 1'b0;
      rd(4'h0, st(0,0,0,0,0,0));
      wr(4'h0, C_PWR);
      rd(4'h0, st(1,0,0,0,0,1));
      wr(4'h0, 32'h0);
      rd(4'h0, st(1,0,0,0,0,1));
      wr(4'h1, 32'h1f);
      plug <= 1'b0;
      cyc(2);
      wr(4'h1, 32'h1f);
      for (i = 0; i < 3; i++) begin
         wr(4'h0, cmds[i]);
         rd(4'h0, st(0,0,0,0,0,1));
         rd(4'h1, 32'h1);
         wr(4'h1, 32'h1f);
      end
      plug <= 1'b1;
      cyc(2);
      wr(4'h1, 32'h1f);
      rcnt = 0;
      wr(4'h0, C_RST);
      rd(4'h0, st(1,0,0,0,1,1));
      chk({31'h0, PORT_RESET_DRIVE}, 32'h1);
      waitclr(BIT_RESET);
      rd(4'h0, st(1,1,0,0,0,1));
      rd(4'h1, 32'h10);
      chk({31'h0, rcnt >= RST_LEN && rcnt <= RST_LEN + 2}, 32'h1);
      wr(4'h1, 32'h1f);
      wr(4'h0, C_CLREN);
      rd(4'h0, st(1,0,0,0,0,1));
      wr(4'h0, C_SETEN);
      rd(4'h0, st(1,1,0,0,0,1));
      wr(4'h1, 32'h1f);
      wr(4'h0, C_RES);
      rd(4'h1, 32'h0);
      wr(4'h0, C_SUSP);
      rd(4'h0, st(1,1,1,0,0,1));
      chk({31'h0, PORT_SUSPEND_DRIVE}, 32'h1);
      wr(4'h0, C_RES);
      rd(4'h0, st(1,1,1,0,0,1));
      chk({31'h0, PORT_RESUME_DRIVE}, 32'h1);
      waitclr(BIT_SUSPEND);
      rd(4'h0, st(1,1,0,0,0,1));
      rd(4'h1, 32'h4);
      wr(4'h1, 32'h1f);
      wr(4'h0, C_SUSP);
      wdly <= 4'($urandom_range(9, 1));
      wake <= 1'b1;
      for (i = 0; i < 30 && WAKE_TO_CTL !== 1'b1; i++) cyc(1);
      chk({31'h0, WAKE_TO_CTL}, 32'h1);
      CTL_WAKE_STATE <= 1'b1;
      cyc(2);
      CTL_WAKE_STATE <= 1'b0;
      wake <= 1'b0;
      rd(4'h0, 32'h0, 32'h4);
      cyc(RSM_LEN + 4);
      wr(4'h1, 32'h1f);
      wr(4'h0, C_SUSP);
      wr(4'h0, C_RST);
      waitclr(BIT_RESET);
      rd(4'h0, st(1,1,0,0,0,1));
      wr(4'h1, 32'h1f);
      err <= 1'b1;
      cyc(2);
      err <= 1'b0;
      rd(4'h0, st(1,0,0,0,0,1));
      rd(4'h1, 32'h2);
      wr(4'h1, 32'h1f);
      wr(4'h0, C_SETEN);
      plug <= 1'b0;
      cyc(2);
      rd(4'h0, st(0,0,0,0,0,1));
      rd(4'h1, 32'h2, 32'h2);
      plug <= 1'b1;
      wr(4'h0, C_SETEN);
      wr(4'h1, 32'h1f);
      wr(4'h2, 32'h0);
      oc <= 1'b1;
      cyc(2);
      rd(4'h0, 32'h0, 32'h8);
      wr(4'h2, 32'h1);
      rd(4'h0, st(0,0,0,1,0,0));
      rd(4'h1, 32'h2, 32'h2);
      oc <= 1'b0;
      cyc(2);
      rd(4'h0, st(0,0,0,0,0,0));
      wr(4'h0, C_PWR);
      wr(4'h0, C_RST);
      waitclr(BIT_RESET);
      wr(4'h0, C_SUSP);
      wr(4'h0, C_NOPWR);
      rd(4'h0, st(0,0,0,0,0,0));
      wr(4'h0, C_PWR);
      for (i = 0; i < 16; i++) begin
         ra = 4'($urandom_range(15, 3));
         rdat = $urandom;
         wr(ra, rdat);
         rd(ra, 32'h0);
         rd(4'h0, st(1,0,0,0,0,1));
      end
      give_verdict();
   end

   // the whole sequence needs several hundred cycles
   initial begin
      repeat (20000) @(posedge CLK);
      failures++;
      give_verdict();
   end
endmodule

/* sim/usb_dev_model.sv */
// behavioural usb device seen at the downstream side of the root port
`timescale 1ns/1ps
module usb_dev_model (
   input  wire logic       clk,
   input  wire logic       plug,
   input  wire logic       oc,
   input  wire logic       err,
   input  wire logic       wake,
   input  wire logic [3:0] wake_dly,
   input  wire logic       suspend_in,
   output logic            attached,
   output logic            overcurrent,
   output logic            bus_error,
   output logic            remote_wake
);
   logic [3:0] wait_cnt;

   assign attached    = plug;
   assign overcurrent = oc;
   // a detached device cannot corrupt traffic
   assign bus_error   = err & plug;

   // wake is only signalled while suspended; wake_dly lets it answer late
   always_ff @(posedge clk) begin
      if (!(wake && suspend_in)) begin
         wait_cnt    <= 4'h0;
         remote_wake <= 1'b0;
      end else if (wait_cnt < wake_dly) begin
         wait_cnt <= wait_cnt + 4'h1;
      end else begin
         remote_wake <= 1'b1;
      end
   end
endmodule
